// File: sfr_access_and_skip_execution.sv
// Purpose: execute-stage handling of special registers, bit ops, skip and clear
// Assumes: one instruction per clk_sys cycle, file read data valid same cycle
// Notes:   outputs apart from fileRdAddr are registered; file writes land one cycle after execute
// Function
// - every file register usable as source/destination
// - instruction flags override bits written to status
// - pc low write loads high from latch
// - pc high byte not file-addressable
// - bit ops rewrite whole byte, change one bit
// - clear writes zero then sets zero flag
`timescale 1ns/10ps
module sfr_access_and_skip_execution (
    input  wire logic                  clk_sys,     // core instruction clock
    input  wire logic                  resetn,      // async active-low reset
    input  wire sfr_exec_pkg::instr_s  instrIn,     // instruction being executed
    input  wire logic [7:0]            fileRdData,  // byte read from addressed file reg
    input  wire sfr_exec_pkg::alu_s    aluIn,       // result of byte-oriented alu ops
    output logic [6:0]                 fileRdAddr,  // address read this cycle
    output sfr_exec_pkg::fwrite_s      fileWrite,   // registered file write
    output logic [7:0]                 statusOut,   // status register contents
    output logic [7:0]                 pcLowByte,   // pc_low_byte
    output logic [4:0]                 pcHighByte,  // pc_high_byte
    output logic [7:0]                 pcHighLatch, // pc_high_latch
    output logic [7:0]                 workingReg,  // working_register
    output logic                       pcLoad,      // pc was written by an instruction
    output logic                       flushNext    // discard prefetched instruction
);
    // reset release synchroniser
    logic rstMeta_reg;  // first stage, read only by the second
    logic rstSync_reg;  // synchronised reset, active low

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    // execute state: normal or the second, nop cycle of a skip
    typedef enum logic [0:0] {
        ST_RUN  = 1'b0,
        ST_SKIP = 1'b1
    } exec_e;

    exec_e       state_reg;      // current state
    exec_e       state_next;     // next state
    logic [7:0]  status_reg;     // status register storage
    logic [7:0]  pcLow_reg;      // pc low byte
    logic [4:0]  pcHigh_reg;     // pc high byte, not mapped
    logic [7:0]  pcLatch_reg;    // high holding latch
    logic [7:0]  workReg_reg;    // working register
    logic        pcLoad_reg;     // pc load pulse
    logic        flush_reg;      // flush pulse
    logic        wrEn_reg;       // file write strobe
    logic [6:0]  wrAddr_reg;     // file write address
    logic [7:0]  wrData_reg;     // file write data

    logic [13:0] word;           // effective word, nop while skipping
    logic [6:0]  fAddr;          // file field
    logic [2:0]  bitSel;         // bit-select field
    logic [7:0]  srcByte;        // operand after special-register muxing
    logic        isSkip;         // bit_test_skip_if_set
    logic        isClear;        // clear_file_register
    logic        isBitClr;       // bit clear
    logic        isBitSet;       // bit set
    logic        isByteOp;       // byte op with alu result
    logic [7:0]  result;         // byte to be written
    logic        toFile;         // result goes to file
    logic        setZ;           // zero flag affected
    logic        setC;           // carry flags affected
    logic        zVal;           // zero flag value
    logic        cVal;           // carry value
    logic        digitVal;       // digit carry value
    logic [7:0]  statusNext;     // status after this instruction

    // one-hot mask of the selected bit, used by set and clear
    function automatic logic [7:0] bitMask(input logic [2:0] sel);
        bitMask = 8'h01 << sel;
    endfunction

    // read mux for special registers held here
    function automatic logic [7:0] readFile(input logic [6:0] a, input logic [7:0] ext,
                                            input logic [7:0] st, input logic [7:0] pl,
                                            input logic [7:0] lt);
        if (a == sfr_exec_pkg::ADDR_STATUS) begin
            readFile = st;
        end else if (a == sfr_exec_pkg::ADDR_PCLOW) begin
            readFile = pl;
        end else if (a == sfr_exec_pkg::ADDR_PCLATCH) begin
            readFile = lt;
        end else begin
            readFile = ext;
        end
    endfunction

    // decode and compute result
    always_comb begin
        word     = (state_reg == ST_SKIP || !instrIn.valid) ? sfr_exec_pkg::NOP_WORD : instrIn.word;
        fAddr    = word[6:0];
        bitSel   = word[9:7];
        srcByte  = readFile(fAddr, fileRdData, status_reg, pcLow_reg, pcLatch_reg);
        isSkip   = word[13:10] == sfr_exec_pkg::OPC_BIT_SKIP;
        isClear  = word[13:7] == sfr_exec_pkg::OPC_CLEAR_FR;
        isBitClr = word[13:10] == sfr_exec_pkg::OPC_BIT_CLR;
        isBitSet = word[13:10] == sfr_exec_pkg::OPC_BIT_SET;
        isByteOp = (word[13:12] == sfr_exec_pkg::OPC_BYTE_OPS) && !isClear && (word != sfr_exec_pkg::NOP_WORD);
        result   = srcByte;
        toFile   = 1'b0;
        setZ     = 1'b0;
        setC     = 1'b0;
        zVal     = 1'b0;
        cVal     = 1'b0;
        digitVal = 1'b0;
        if (isClear) begin
            result = sfr_exec_pkg::BYTE_ZERO;
            toFile = 1'b1;
            setZ   = 1'b1;
            zVal   = 1'b1;
        end else if (isBitClr) begin
            result = srcByte & ~bitMask(bitSel);
            toFile = 1'b1;
        end else if (isBitSet) begin
            result = srcByte | bitMask(bitSel);
            toFile = 1'b1;
        end else if (isByteOp) begin
            result = aluIn.value;
            toFile = aluIn.toFile;
            setZ   = aluIn.setsZero;
            setC   = aluIn.setsCarry;
            zVal   = aluIn.zero;
            cVal   = aluIn.carry;
            digitVal = aluIn.digitCarry;
        end
        // skip leaves everything untouched apart from the state
        state_next = (state_reg == ST_RUN && isSkip && srcByte[bitSel]) ? ST_SKIP : ST_RUN;
        // status: written byte first, then the instruction's own flags on top
        statusNext = status_reg;
        if (toFile && fAddr == sfr_exec_pkg::ADDR_STATUS) begin
            statusNext = result;
        end
        if (setZ) begin
            statusNext[sfr_exec_pkg::BIT_ZERO] = zVal;
        end
        if (setC) begin
            statusNext[sfr_exec_pkg::BIT_CARRY] = cVal;
            statusNext[sfr_exec_pkg::BIT_DIGIT] = digitVal;
        end
    end

    // skip state register
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            state_reg <= ST_RUN;
            flush_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            flush_reg <= (state_next == ST_SKIP);
        end
    end

    // status register with flag override
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            status_reg <= sfr_exec_pkg::STATUS_RESET;
        end else begin
            status_reg <= statusNext;
        end
    end

    // program counter bytes and latch
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            pcLow_reg   <= sfr_exec_pkg::BYTE_ZERO;
            pcHigh_reg  <= sfr_exec_pkg::PCHI_RESET;
            pcLatch_reg <= sfr_exec_pkg::BYTE_ZERO;
            pcLoad_reg  <= 1'b0;
        end else begin
            pcLoad_reg <= toFile && fAddr == sfr_exec_pkg::ADDR_PCLOW;
            if (toFile && fAddr == sfr_exec_pkg::ADDR_PCLOW) begin
                pcLow_reg  <= result;
                pcHigh_reg <= pcLatch_reg[4:0];
            end else begin
                pcLow_reg <= pcLow_reg + 8'h01;
            end
            if (toFile && fAddr == sfr_exec_pkg::ADDR_PCLATCH) begin
                pcLatch_reg <= result;
            end
        end
    end

    // working register and external file writes
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            workReg_reg <= sfr_exec_pkg::BYTE_ZERO;
            wrEn_reg   <= 1'b0;
            wrAddr_reg <= 7'h00;
            wrData_reg <= sfr_exec_pkg::BYTE_ZERO;
        end else begin
            if (isByteOp && !aluIn.toFile) begin
                workReg_reg <= result;
            end
            wrEn_reg   <= toFile && fAddr != sfr_exec_pkg::ADDR_STATUS
                          && fAddr != sfr_exec_pkg::ADDR_PCLOW && fAddr != sfr_exec_pkg::ADDR_PCLATCH;
            wrAddr_reg <= fAddr;
            wrData_reg <= result;
        end
    end

    // outputs from flip-flops, except fileRdAddr taken straight from instrIn
    assign fileRdAddr       = instrIn.word[6:0];
    assign fileWrite.en     = wrEn_reg;
    assign fileWrite.addr   = wrAddr_reg;
    assign fileWrite.data   = wrData_reg;
    assign statusOut        = status_reg;
    assign pcLowByte        = pcLow_reg;
    assign pcHighByte       = pcHigh_reg;
    assign pcHighLatch      = pcLatch_reg;
    assign workingReg       = workReg_reg;
    assign pcLoad           = pcLoad_reg;
    assign flushNext        = flush_reg;
endmodule

// File: sfr_exec_pkg.sv
// Purpose: shared constants and carriers for the special-register execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   file addresses of the status register, low pc byte and high latch
package sfr_exec_pkg;
    localparam logic [6:0]  ADDR_STATUS   = 7'h03;   // status register file address
    localparam logic [6:0]  ADDR_PCLOW    = 7'h02;   // pc_low_byte file address
    localparam logic [6:0]  ADDR_PCLATCH  = 7'h0A;   // pc_high_latch file address
    localparam int          BIT_CARRY     = 0;       // carry flag position
    localparam int          BIT_DIGIT     = 1;       // digit_carry_flag position
    localparam int          BIT_ZERO      = 2;       // zero flag position
    localparam logic [7:0]  STATUS_RESET  = 8'h18;   // status value after reset
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;   // cleared byte
    localparam logic [4:0]  PCHI_RESET    = 5'h00;   // pc high byte after reset
    localparam logic [13:0] NOP_WORD      = 14'h0000;// no-operation encoding
    localparam logic [3:0]  OPC_BIT_SKIP  = 4'h7;    // top bits 01 11 of bit_test_skip_if_set
    localparam logic [6:0]  OPC_CLEAR_FR  = 7'h03;   // top bits 00 0001 1 of clear_file_register
    localparam logic [3:0]  OPC_BIT_CLR   = 4'h4;    // top bits 01 00 bit clear
    localparam logic [3:0]  OPC_BIT_SET   = 4'h5;    // top bits 01 01 bit set
    localparam logic [1:0]  OPC_BYTE_OPS  = 2'h0;    // top bits 00 byte-oriented ops

    // decoded instruction handed to the execute stage
    typedef struct packed {
        logic [13:0] word;      // raw instruction word
        logic        valid;     // word is a real instruction
    } instr_s;

    // one file-register write request
    typedef struct packed {
        logic       en;         // write strobe
        logic [6:0] addr;       // file address
        logic [7:0] data;       // byte to store
    } fwrite_s;

    // alu result from the arithmetic path
    typedef struct packed {
        logic [7:0] value;      // 8-bit result
        logic       zero;       // zero flag result
        logic       carry;      // carry flag result
        logic       digitCarry; // digit_carry_flag result
        logic       setsZero;   // instruction affects zero
        logic       setsCarry;  // instruction affects carry and digit carry
        logic       toFile;     // destination is file (else working_register)
    } alu_s;
endpackage

// File: file_array_model.sv
// Purpose: behavioural file-register array on the far side of the execute block
// Assumes: combinational read, writes land on the clock edge
// Notes:   special addresses mirror the core's own registers
`timescale 1ns/10ps
module file_array_model (
    input  wire logic                  clk_sys,     // core clock
    input  wire logic [6:0]            fileRdAddr,  // read address
    input  wire sfr_exec_pkg::fwrite_s fileWrite,   // write request
    input  wire logic [7:0]            statusOut,   // status mirror
    input  wire logic [7:0]            pcLowByte,   // pc low mirror
    input  wire logic [7:0]            pcHighLatch, // latch mirror
    output logic [7:0]                 fileRdData   // read byte
);
    logic [7:0] mem [128];  // plain registers, all start at A5
    initial for (int i = 0; i < 128; i++) mem[i] = 8'hA5;
    // store writes at the edge
    always @(posedge clk_sys) if (fileWrite.en) mem[fileWrite.addr] <= fileWrite.data;
    // special registers read like any other, pc high has no address
    always_comb begin
        case (fileRdAddr)
            sfr_exec_pkg::ADDR_STATUS:  fileRdData = statusOut;
            sfr_exec_pkg::ADDR_PCLOW:   fileRdData = pcLowByte;
            sfr_exec_pkg::ADDR_PCLATCH: fileRdData = pcHighLatch;
            default:                    fileRdData = mem[fileRdAddr];
        endcase
    end
endmodule

// File: sfr_exec_assertions.sv
// Purpose: port-level checks of the special-register execute block
// Assumes: one instruction per cycle, registered answers
// Notes:   an instruction in the skip nop slot is ignored
`timescale 1ns/10ps
module sfr_exec_assertions (
    input wire logic                  clk_sys,
    input wire logic                  resetn,
    input wire sfr_exec_pkg::instr_s  instrIn,
    input wire logic [7:0]            fileRdData,
    input wire sfr_exec_pkg::alu_s    aluIn,
    input wire logic [6:0]            fileRdAddr,
    input wire sfr_exec_pkg::fwrite_s fileWrite,
    input wire logic [7:0]            statusOut,
    input wire logic [7:0]            pcLowByte,
    input wire logic [4:0]            pcHighByte,
    input wire logic [7:0]            pcHighLatch,
    input wire logic [7:0]            workingReg,
    input wire logic                  pcLoad,
    input wire logic                  flushNext
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [13:0] w;    // word under execution
    logic        go;   // instruction really taken
    logic        spec; // special address
    logic        bop;  // bit set or clear
    logic [7:0]  msk;  // selected bit
    assign w = instrIn.word;
    assign go = instrIn.valid && !flushNext;
    assign spec = w[6:0] inside {sfr_exec_pkg::ADDR_STATUS, sfr_exec_pkg::ADDR_PCLOW, sfr_exec_pkg::ADDR_PCLATCH};
    assign bop = w[13:10] == sfr_exec_pkg::OPC_BIT_CLR || w[13:10] == sfr_exec_pkg::OPC_BIT_SET;
    assign msk = 8'h01 << w[9:7];
    sequence s_skip; go && w[13:10] == sfr_exec_pkg::OPC_BIT_SKIP; endsequence
    sequence s_nop_slot; flushNext && !fileWrite.en ##1 !flushNext && !fileWrite.en && !pcLoad; endsequence
    property p_clr_st; go && w == 14'h0183 |=> statusOut == 8'h04; endproperty
    property p_clr_f; go && w[13:7] == sfr_exec_pkg::OPC_CLEAR_FR && !spec
        |=> fileWrite.en && fileWrite.data == 8'h00 && statusOut[2]; endproperty
    property p_skip; s_skip ##0 fileRdData[w[9:7]] |=> s_nop_slot; endproperty
    property p_skip_miss; s_skip ##0 !fileRdData[w[9:7]] |=> !flushNext && $stable(statusOut); endproperty
    property p_bit_rmw; go && bop && !spec |=> fileWrite.en && fileWrite.addr == $past(w[6:0])
        && fileWrite.data == ($past(w[10]) ? $past(fileRdData) | $past(msk) : $past(fileRdData) & ~$past(msk));
    endproperty
    property p_hi_hold; !pcLoad |-> $stable(pcHighByte); endproperty
    property p_low_wr; go && (bop || w[13:7] == sfr_exec_pkg::OPC_CLEAR_FR) && w[6:0] == sfr_exec_pkg::ADDR_PCLOW
        |=> pcLoad && pcHighByte == $past(pcHighLatch[4:0]) && !fileWrite.en; endproperty
    property p_alu_st; go && w[13:12] == sfr_exec_pkg::OPC_BYTE_OPS && w[13:7] != sfr_exec_pkg::OPC_CLEAR_FR
        && w != sfr_exec_pkg::NOP_WORD && aluIn.toFile && aluIn.setsZero && w[6:0] == sfr_exec_pkg::ADDR_STATUS
        |=> statusOut[2] == $past(aluIn.zero); endproperty
    property p_rd_addr; instrIn.valid |-> fileRdAddr == w[6:0]; endproperty
    a_clr_st:    assert property (p_clr_st) else $error("clear of status not 04");
    a_clr_f:     assert property (p_clr_f) else $error("clear did not write zero");
    a_skip:      assert property (p_skip) else $error("skip nop slot wrong");
    a_skip_miss: assert property (p_skip_miss) else $error("skip miss flushed or moved flags");
    a_bit_rmw:   assert property (p_bit_rmw) else $error("bit op wrote wrong byte");
    a_low_wr:    assert property (p_low_wr) else $error("pc low write did not load high");
    a_hi_hold:   assert property (p_hi_hold) else $error("pc high moved without low write");
    a_alu_st:    assert property (p_alu_st) else $error("zero flag not from alu");
    a_rd_addr:   assert property (p_rd_addr) else $error("read address wrong");
endmodule
bind sfr_access_and_skip_execution sfr_exec_assertions u_chk (.clk_sys, .resetn, .instrIn, .fileRdData, .aluIn,
    .fileRdAddr, .fileWrite, .statusOut, .pcLowByte, .pcHighByte, .pcHighLatch, .workingReg, .pcLoad, .flushNext);

// File: tb_top.sv
// Purpose: directed bench for the special-register execute block
// Assumes: inputs move 1 ns after the rising edge
// Notes:   file array preloaded with A5 by the partner model
`timescale 1ns/10ps
module tb_top;
    logic                  clk_sys = 0;          // 200 MHz clock
    logic                  resetn = 0;           // active-low reset
    sfr_exec_pkg::instr_s  instrIn = '0;         // instruction in
    sfr_exec_pkg::alu_s    aluIn = '0;           // alu result in
    sfr_exec_pkg::fwrite_s fileWrite;            // file write out
    logic [7:0]            fileRdData, statusOut, pcLowByte, pcHighLatch, workingReg;
    logic [6:0]            fileRdAddr;           // read address
    logic [4:0]            pcHighByte;           // pc high
    logic                  pcLoad, flushNext;    // pulses
    int                    n_errors = 0;         // mismatches
    int                    checks = 0;           // comparisons
    int                    cyc = 0;              // timeout count
    always #2.5 clk_sys = ~clk_sys;
    sfr_access_and_skip_execution dut (.clk_sys, .resetn, .instrIn, .fileRdData, .aluIn, .fileRdAddr,
        .fileWrite, .statusOut, .pcLowByte, .pcHighByte, .pcHighLatch, .workingReg, .pcLoad, .flushNext);
    file_array_model far (.clk_sys, .fileRdAddr, .fileWrite, .statusOut, .pcLowByte, .pcHighLatch, .fileRdData);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // present one word, let its edge land
    task exec(input logic [13:0] w);
        instrIn = '{word: w, valid: 1'b1};
        @(posedge clk_sys);
        #1;
    endtask
    task close_out;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // clear of status and of a plain register
    task t_clear;
        exec(14'h0183); chk(statusOut, 8'h04);
        exec(14'h01A0); chk(fileWrite, {1'b1, 7'h20, 8'h00});
    endtask
    // set and clear one bit, others kept
    task t_bits;
        exec(14'h14A1); chk(fileWrite, {1'b1, 7'h21, 8'hA7});
        exec(14'h1022); chk(fileWrite, {1'b1, 7'h22, 8'hA4});
        exec(14'h1603); chk(statusOut, 8'h14);
    endtask
    // skip taken then skip not taken
    task t_skip;
        exec(14'h1C23); chk(flushNext, 1'b1);
        exec(14'h01A4); chk({flushNext, fileWrite.en}, 2'b00);
        exec(14'h1CA5); chk({flushNext, statusOut}, {1'b0, 8'h14});
        exec(14'h01A6); chk(fileWrite, {1'b1, 7'h26, 8'h00});
    endtask
    // pc low writes load pc high from the latch
    task t_pc_low;
        exec(14'h150A); chk(pcHighLatch, 8'h04);
        exec(14'h0182); chk({pcLoad, pcHighByte, pcLowByte, fileWrite.en}, {1'b1, 5'h04, 8'h00, 1'b0});
        exec(14'h1782); chk({pcLoad, pcLowByte}, {1'b1, 8'h80});
    endtask
    // alu flags override the byte stored in status
    task t_alu;
        aluIn = '{value: 8'hFF, zero: 1'b0, carry: 1'b1, digitCarry: 1'b1, setsZero: 1'b1, setsCarry: 1'b1,
                  toFile: 1'b1};
        exec(14'h0783); chk(statusOut, 8'hFB);
        aluIn = '{value: 8'h5A, zero: 1'b0, carry: 1'b0, digitCarry: 1'b0, setsZero: 1'b0, setsCarry: 1'b0,
                  toFile: 1'b0};
        exec(14'h0820); chk({workingReg, statusOut}, {8'h5A, 8'hFB});
        aluIn = '0;
    endtask
    // reset in mid-run brings the held registers back to their reset values
    task t_reset;
        instrIn = '0;
        resetn = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 chk({statusOut, pcHighLatch}, {sfr_exec_pkg::STATUS_RESET, 8'h00});
        chk({pcHighByte, pcLoad, flushNext}, {5'h00, 2'b00});
    endtask
    // cut a hang short
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 500) begin
            n_errors++;
            close_out;
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1;
        repeat (3) @(posedge clk_sys);
        #1 chk(statusOut, sfr_exec_pkg::STATUS_RESET);
        t_clear;
        t_bits;
        t_skip;
        t_pc_low;
        t_reset;
        t_alu;
        instrIn.valid = 1'b0;
        close_out;
    end
endmodule
